// ==== cds_pkg.sv ====
// package with opcode fields, widths and carrier structs for the decoder
package cds_pkg;
  localparam int unsigned CDS_IW       = 14;
  localparam int unsigned CDS_DW       = 8;
  localparam int unsigned CDS_AW       = 7;
  localparam int unsigned CDS_OP_MSB   = 13;
  localparam int unsigned CDS_OP_LSB   = 8;
  localparam int unsigned CDS_DEST_BIT = 7;
  localparam logic [5:0]  CDS_OP_COMP  = 6'h09;
  localparam logic [5:0]  CDS_OP_DSKZ  = 6'h0b;
  localparam logic [7:0]  CDS_ONE      = 8'h01;
  localparam logic [7:0]  CDS_ZERO     = 8'h00;
  localparam logic [7:0]  CDS_RST_DATA = 8'h00;

  // write-back request towards the register file or working register
  typedef struct packed {
    logic       wr_w;
    logic       wr_f;
    logic [6:0] addr;
    logic [7:0] data;
  } cds_wb_t;

  // status flag update request
  typedef struct packed {
    logic z_we;
    logic z_val;
  } cds_flag_t;
endpackage

// ==== cds_alu.sv ====
// arithmetic unit: complement or decrement with zero detect
`timescale 1ns/1ns
`default_nettype none
module cds_alu
  import cds_pkg::*;
#(
  parameter int unsigned DW = CDS_DW
) (
  input  wire logic [DW-1:0] operand,
  input  wire logic          sel_dec,
  output logic      [DW-1:0] result,
  output logic               is_zero
);
  initial begin
    if (DW != CDS_DW) $error("cds_alu supports only 8-bit data");
  end

  // select inverse or operand minus one, then test for zero
  always_comb begin
    if (sel_dec) begin
      result = operand - DW'(CDS_ONE);
    end else begin
      result = ~operand;
    end
    is_zero = (result == DW'(CDS_ZERO));
  end
endmodule
`default_nettype wire

// ==== cds_exec.sv ====
// execute stage for the complement and decrement-skip-zero instructions
// Overview of operation
// - complement_reg_instr writes the inverted register to the destination and updates the zero flag.
// - decrement_skip_zero_instr subtracts one from the register and tests the result for zero.
// - a cleared destination bit writes the working register, a set bit writes the register back.
// - a zero result from the decrement discards the already fetched next instruction.
// - the skip runs a no-operation cycle so the instruction takes two cycles, else one.
`timescale 1ns/1ns
`default_nettype none
module cds_exec
  import cds_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              instr_valid,
  input  wire logic [CDS_IW-1:0] instr,
  input  wire logic [CDS_DW-1:0] reg_rdata,
  output logic      [CDS_AW-1:0] reg_raddr,
  output cds_wb_t                wb,
  output cds_flag_t              flag,
  output logic                   flush,
  output logic                   nop_cycle,
  output logic                   pc_advance,
  output logic                   busy
);
  typedef enum logic [0:0] {
    CDS_ST_EXEC = 1'b0,
    CDS_ST_NOP  = 1'b1
  } cds_state_t;

  cds_state_t        state;
  cds_state_t        next_state;
  cds_wb_t           next_wb;
  cds_flag_t         next_flag;
  logic              next_flush;
  logic              next_nop_cycle;
  logic              next_pc_advance;
  logic [5:0]        opcode;
  logic              dest;
  logic              is_comp;
  logic              is_dskz;
  logic [CDS_DW-1:0] alu_res;
  logic              alu_zero;

  // field decode of the current instruction word
  assign opcode    = instr[CDS_OP_MSB:CDS_OP_LSB];
  assign dest      = instr[CDS_DEST_BIT];
  assign reg_raddr = instr[CDS_AW-1:0];
  assign is_comp   = instr_valid && (state == CDS_ST_EXEC)
                     && (opcode == CDS_OP_COMP);
  assign is_dskz   = instr_valid && (state == CDS_ST_EXEC)
                     && (opcode == CDS_OP_DSKZ);
  assign busy      = (state == CDS_ST_NOP);

  cds_alu #(
    .DW (CDS_DW)
  ) u_alu (
    .operand (reg_rdata),
    .sel_dec (is_dskz),
    .result  (alu_res),
    .is_zero (alu_zero)
  );

  // next-value logic for the execute cycle and the skip cycle
  always_comb begin
    next_state      = CDS_ST_EXEC;
    next_wb         = '{wr_w: 1'b0, wr_f: 1'b0, addr: '0,
                        data: CDS_RST_DATA};
    next_flag       = '{z_we: 1'b0, z_val: 1'b0};
    next_flush      = 1'b0;
    next_nop_cycle  = 1'b0;
    next_pc_advance = 1'b0;
    case (state)
      CDS_ST_EXEC: begin
        if (is_comp || is_dskz) begin
          next_wb.wr_w    = ~dest;
          next_wb.wr_f    = dest;
          next_wb.addr    = reg_raddr;
          next_wb.data    = alu_res;
          next_pc_advance = 1'b1;
        end
        if (is_comp) begin
          next_flag.z_we  = 1'b1;
          next_flag.z_val = alu_zero;
        end
        if (is_dskz && alu_zero) begin
          next_flush = 1'b1;
          next_state = CDS_ST_NOP;
        end
      end
      CDS_ST_NOP: begin
        next_nop_cycle  = 1'b1;
        next_pc_advance = 1'b1;
        next_state      = CDS_ST_EXEC;
      end
      default: begin
        next_state = CDS_ST_EXEC;
      end
    endcase
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state      <= CDS_ST_EXEC;
      wb         <= '{wr_w: 1'b0, wr_f: 1'b0, addr: '0,
                      data: CDS_RST_DATA};
      flag       <= '{z_we: 1'b0, z_val: 1'b0};
      flush      <= 1'b0;
      nop_cycle  <= 1'b0;
      pc_advance <= 1'b0;
    end else begin
      state      <= next_state;
      wb         <= next_wb;
      flag       <= next_flag;
      flush      <= next_flush;
      nop_cycle  <= next_nop_cycle;
      pc_advance <= next_pc_advance;
    end
  end

  // checks
  sequence s_dskz_zero;
    is_dskz && alu_zero;
  endsequence

  sequence s_skip_steps;
    ##1 (flush && busy) ##1 (nop_cycle && !busy);
  endsequence

  AST_COMP_DATA: assert property (@(posedge sys_clk) disable iff (!nrst)
    is_comp |=> (wb.data == ~$past(reg_rdata)) && flag.z_we
                && (flag.z_val == (wb.data == CDS_ZERO)))
    else $error("complement result or zero flag wrong");

  AST_DSKZ_DATA: assert property (@(posedge sys_clk) disable iff (!nrst)
    is_dskz |=> wb.data == ($past(reg_rdata) - CDS_ONE))
    else $error("decrement result wrong");

  AST_DEST_SEL: assert property (@(posedge sys_clk) disable iff (!nrst)
    (is_comp || is_dskz) |=> (wb.wr_w == !$past(dest))
                             && (wb.wr_f == $past(dest))
                             && (wb.addr == $past(reg_raddr)))
    else $error("destination select wrong");

  AST_FLUSH: assert property (@(posedge sys_clk) disable iff (!nrst)
    flush |-> $past(is_dskz) && $past(alu_zero))
    else $error("flush without zero decrement");

  AST_SKIP_SEQ: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_dskz_zero |-> s_skip_steps)
    else $error("skip did not run one no-operation cycle");

  AST_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (is_dskz && !alu_zero) |=> !flush && !busy ##1 !nop_cycle)
    else $error("nonzero decrement took extra cycle");

  AST_NO_FLAGS: assert property (@(posedge sys_clk) disable iff (!nrst)
    is_dskz |=> !flag.z_we && pc_advance)
    else $error("decrement touched status flags");

  // slot holding a valid word that neither instruction decodes
  logic refused_op;
  assign refused_op = instr_valid && !busy && !is_comp && !is_dskz;

  // outputs of one cycle in which nothing is executed
  sequence s_quiet;
    !wb.wr_w && !wb.wr_f && !flag.z_we && !flush;
  endsequence

  // reset leaves every registered output low on the next edge
  AST_RESET_QUIET: assert property (@(posedge sys_clk)
    !nrst |=> !wb.wr_w && !wb.wr_f && !flag.z_we && !flush
              && !nop_cycle && !pc_advance && !busy)
    else $error("outputs not cleared by reset");

  // unknown opcodes must not write, flag or advance
  AST_OTHER_OP: assert property (@(posedge sys_clk) disable iff (!nrst)
    refused_op |=> s_quiet and !pc_advance)
    else $error("undecoded opcode produced outputs");

  // the word presented during the skip cycle is thrown away
  AST_BUSY_REFUSE: assert property (@(posedge sys_clk) disable iff (!nrst)
    busy |=> s_quiet)
    else $error("instruction executed during skip cycle");

  // only one destination is written per instruction
  AST_ONE_DEST: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(wb.wr_w && wb.wr_f))
    else $error("both destinations written");

  // flush is a single-cycle pulse
  AST_FLUSH_PULSE: assert property (@(posedge sys_clk) disable iff (!nrst)
    flush |=> !flush)
    else $error("flush held longer than one cycle");

  // the no-operation cycle only ever follows a flush
  AST_NOP_AFTER_FLUSH: assert property (@(posedge sys_clk) disable iff (!nrst)
    nop_cycle |-> $past(flush))
    else $error("no-operation cycle without flush");

  // the program counter moves only for an executed or skipped slot
  AST_PC_SOURCE: assert property (@(posedge sys_clk) disable iff (!nrst)
    pc_advance |-> $past(is_comp || is_dskz) || nop_cycle)
    else $error("program counter advanced without cause");

  // the skip state never lasts two cycles in a row
  AST_BUSY_ONE: assert property (@(posedge sys_clk) disable iff (!nrst)
    busy |=> !busy)
    else $error("skip state held too long");

  // zero flag from a complement is set when the operand is all ones
  AST_COMP_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
    (is_comp && (reg_rdata == 8'hff)) |=> flag.z_val)
    else $error("zero flag not set for all-ones operand");

  // a nonzero decrement never requests a flush
  AST_NZ_NO_FLUSH: assert property (@(posedge sys_clk) disable iff (!nrst)
    (is_dskz && (reg_rdata != CDS_ONE)) |=> !flush && !nop_cycle)
    else $error("nonzero decrement flushed");
endmodule
`default_nettype wire

// ==== cds_exec_tb.sv ====
// testbench for the complement and decrement-skip-zero execute stage
`timescale 1ns/1ns
`default_nettype none
module cds_exec_tb;
  import cds_pkg::*;
  logic              sys_clk;
  logic              nrst;
  logic              instr_valid;
  logic [CDS_IW-1:0] instr;
  logic [CDS_DW-1:0] reg_rdata;
  logic [CDS_AW-1:0] reg_raddr;
  cds_wb_t           wb;
  cds_flag_t         flag;
  logic              flush;
  logic              nop_cycle;
  logic              pc_advance;
  logic              busy;
  int                bad_count;
  int                total_checks;

  cds_exec dut (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .instr_valid (instr_valid),
    .instr       (instr),
    .reg_rdata   (reg_rdata),
    .reg_raddr   (reg_raddr),
    .wb          (wb),
    .flag        (flag),
    .flush       (flush),
    .nop_cycle   (nop_cycle),
    .pc_advance  (pc_advance),
    .busy        (busy)
  );

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // compare and count
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // present one instruction; nv keeps a complement valid behind it
  task automatic issue(input logic [5:0] op, input logic d,
                       input logic [7:0] x, input logic nv);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr       <= {op, d, 7'h2a};
    reg_rdata   <= x;
    #1 chk(reg_raddr, 7'h2a);
    @(posedge sys_clk);
    instr_valid <= nv;
    instr       <= {CDS_OP_COMP, 1'b1, 7'h2a};
    #1;
  endtask

  // complement to both destinations, zero flag clear and set
  task automatic t_comp;
    issue(CDS_OP_COMP, 1'b0, 8'h13, 1'b0);
    chk(wb, {2'b10, 7'h2a, 8'hec});
    chk({flag, pc_advance}, 3'b101);
    issue(CDS_OP_COMP, 1'b1, 8'hff, 1'b0);
    chk(wb, {2'b01, 7'h2a, 8'h00});
    chk({flag, pc_advance}, 3'b111);
  endtask

  // nonzero decrement followed back to back by a complement
  task automatic t_dec_nz;
    issue(CDS_OP_DSKZ, 1'b1, 8'h05, 1'b1);
    chk(wb, {2'b01, 7'h2a, 8'h04});
    chk({flush, busy, flag.z_we, pc_advance}, 4'b0001);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1 chk(wb, {2'b01, 7'h2a, 8'hfa});
    chk({nop_cycle, flag}, 3'b010);
  endtask

  // zero decrement: flush, refused instruction, nop cycle
  task automatic t_dec_z;
    issue(CDS_OP_DSKZ, 1'b0, 8'h01, 1'b1);
    chk(wb, {2'b10, 7'h2a, 8'h00});
    chk({flush, busy, flag.z_we, pc_advance}, 4'b1101);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1 chk({nop_cycle, pc_advance, busy, flush}, 4'b1100);
    chk({wb.wr_w, wb.wr_f, flag.z_we}, 3'b000);
    @(posedge sys_clk);
    #1 chk({nop_cycle, pc_advance, wb.wr_w, wb.wr_f}, 4'b0000);
  endtask

  // other opcodes give no outputs
  task automatic t_other;
    issue(6'h03, 1'b1, 8'h01, 1'b0);
    chk({wb.wr_w, wb.wr_f, flag.z_we, flush, pc_advance}, 5'h00);
    issue(6'h0f, 1'b0, 8'h00, 1'b0);
    chk({wb.wr_w, wb.wr_f, flag.z_we, flush, pc_advance}, 5'h00);
  endtask

  // verdict and end of run
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    nrst        = 1'b0;
    instr_valid = 1'b0;
    instr       = '0;
    reg_rdata   = 8'h00;
    bad_count   = 0;
    total_checks = 0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    t_comp;
    t_dec_nz;
    t_dec_z;
    t_other;
    report_and_stop;
  end
endmodule
`default_nettype wire
